//--- src/crf_core_regs.sv
// Core register file: stack, pointers, operands, banks and status word
`timescale 1ns/1ps
`default_nettype none
module crf_core_regs (
    input  wire logic                       i_clk,
    input  wire logic                       i_resetn,
    input  wire crf_pkg::crf_sfr_req_type   i_sfr,
    input  wire crf_pkg::crf_wreg_req_type  i_wreg,
    input  wire crf_pkg::crf_stack_req_type i_stack,
    input  wire crf_pkg::crf_op_type        i_op,
    input  wire logic                       i_fetch_inc,
    input  wire logic                       i_fetch_load,
    input  wire logic [15:0]                i_fetch_addr,
    output logic [7:0]                      o_sfr_rdata,
    output logic                            o_sfr_bit,
    output logic                            o_sfr_hit,
    output logic [7:0]                      o_wreg_rdata,
    output logic [7:0]                      o_stack_addr,
    output logic [15:0]                     o_table_base_ptr,
    output logic [15:0]                     o_fetch_counter,
    output logic [7:0]                      o_main_operand_reg,
    output logic [7:0]                      o_aux_operand_reg,
    output logic [7:0]                      o_core_status_word
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [7:0]  stack_top_ptr_r;
    logic [7:0]  table_base_lo_r;
    logic [7:0]  table_base_hi_r;
    logic [15:0] fetch_counter_r;
    logic [7:0]  main_operand_reg_r;
    logic [7:0]  aux_operand_reg_r;
    logic [7:0]  status_r;
    logic [7:0]  wreg_mem [crf_pkg::WREG_DEPTH];
    logic [7:0]  wreg_rdata_r;
    logic [7:0]  sfr_rdata_r;
    logic        sfr_bit_r;
    logic        sfr_hit_r;

    // ------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------
    function automatic logic [7:0] bit_merge(input logic [7:0] cur,
                                             input logic [2:0] pos,
                                             input logic       val);
        logic [7:0] tmp;
        tmp      = cur;
        tmp[pos] = val;
        return tmp;
    endfunction

    // Addresses ending in 0 or 8 in the special space are bit addressable
    function automatic logic bit_capable(input logic [7:0] a);
        return a[7] && (a[2:0] == 3'b000);
    endfunction

    // ------------------------------------------------------------------
    // Special register decode
    // ------------------------------------------------------------------
    // Only direct accesses with address bit 7 set reach these registers
    wire in_sfr   = i_sfr.req && i_sfr.addr[7];
    // Bit requests to byte-only addresses are dropped
    wire bit_ok   = !i_sfr.bit_mode || bit_capable(i_sfr.addr);
    wire acc_ok   = in_sfr && bit_ok;
    wire wr_en    = acc_ok && i_sfr.wr;
    wire sel_sp   = (i_sfr.addr == crf_pkg::STACK_ADDR);
    wire sel_lo   = (i_sfr.addr == crf_pkg::TBL_LO_ADDR);
    wire sel_hi   = (i_sfr.addr == crf_pkg::TBL_HI_ADDR);
    wire sel_st   = (i_sfr.addr == crf_pkg::STATUS_ADDR);
    wire sel_a    = (i_sfr.addr == crf_pkg::MAIN_OP_ADDR);
    wire sel_b    = (i_sfr.addr == crf_pkg::AUX_OP_ADDR);
    wire sel_any  = sel_sp | sel_lo | sel_hi | sel_st | sel_a | sel_b;

    // Parity is computed live so it never lags the operand register
    wire parity   = ^main_operand_reg_r;
    wire [7:0] status_view = {status_r[7:1], parity};

    // Unoccupied addresses read a fixed value; writes there are dropped
    wire [7:0] read_byte =
        sel_sp ? stack_top_ptr_r :
        sel_lo ? table_base_lo_r :
        sel_hi ? table_base_hi_r :
        sel_st ? status_view :
        sel_a  ? main_operand_reg_r :
        sel_b  ? aux_operand_reg_r :
                 crf_pkg::UNDEF_READ_VAL;

    // Byte or single bit write value for the selected register
    wire [7:0] wval_sp = i_sfr.bit_mode ?
        bit_merge(stack_top_ptr_r, i_sfr.bit_sel, i_sfr.wdata[0]) : i_sfr.wdata;
    wire [7:0] wval_lo = i_sfr.bit_mode ?
        bit_merge(table_base_lo_r, i_sfr.bit_sel, i_sfr.wdata[0]) : i_sfr.wdata;
    wire [7:0] wval_hi = i_sfr.bit_mode ?
        bit_merge(table_base_hi_r, i_sfr.bit_sel, i_sfr.wdata[0]) : i_sfr.wdata;
    wire [7:0] wval_st = i_sfr.bit_mode ?
        bit_merge(status_view, i_sfr.bit_sel, i_sfr.wdata[0]) : i_sfr.wdata;
    wire [7:0] wval_a  = i_sfr.bit_mode ?
        bit_merge(main_operand_reg_r, i_sfr.bit_sel, i_sfr.wdata[0])
        : i_sfr.wdata;
    wire [7:0] wval_b  = i_sfr.bit_mode ?
        bit_merge(aux_operand_reg_r, i_sfr.bit_sel, i_sfr.wdata[0])
        : i_sfr.wdata;

    // ------------------------------------------------------------------
    // Arithmetic
    // ------------------------------------------------------------------
    logic [7:0] alu_a;
    logic [7:0] alu_b;
    logic       alu_cy;
    logic       alu_half;
    logic       alu_serr;
    logic       alu_arith;
    logic       alu_cy_upd;

    crf_alu_flags u_alu (
        .i_op       (i_op),
        .i_a        (main_operand_reg_r),
        .i_b        (aux_operand_reg_r),
        .i_cy       (status_r[crf_pkg::ST_CARRY]),
        .o_res_a    (alu_a),
        .o_res_b    (alu_b),
        .o_cy       (alu_cy),
        .o_half     (alu_half),
        .o_sign_err (alu_serr),
        .o_arith    (alu_arith),
        .o_cy_upd   (alu_cy_upd)
    );

    wire is_mul_div = (i_op == crf_pkg::CRF_OP_PRODUCT)
                   || (i_op == crf_pkg::CRF_OP_DIVIDE);
    wire b_result   = is_mul_div;
    wire clr_serr   = (i_op == crf_pkg::CRF_OP_CLEAR_SIGN_ERROR);

    // ------------------------------------------------------------------
    // Next values: arithmetic overrides a same-cycle software write
    // ------------------------------------------------------------------
    wire [7:0] a_nxt = alu_cy_upd ? alu_a
                     : (wr_en && sel_a) ? wval_a : main_operand_reg_r;
    wire [7:0] b_nxt = b_result ? alu_b
                     : (wr_en && sel_b) ? wval_b : aux_operand_reg_r;

    logic [7:0] st_nxt;
    always_comb begin
        st_nxt = status_r;
        // Software may write every flag except parity, including the user flag
        if (wr_en && sel_st) begin
            st_nxt = wval_st;
        end
        if (alu_cy_upd) begin
            st_nxt[crf_pkg::ST_CARRY] = alu_cy;
        end
        if (alu_arith && !is_mul_div) begin
            st_nxt[crf_pkg::ST_HALF] = alu_half;
        end
        if (alu_arith) begin
            st_nxt[crf_pkg::ST_SIGN_ERR] = alu_serr;
        end
        if (clr_serr) begin
            st_nxt[crf_pkg::ST_SIGN_ERR] = 1'b0;
        end
        st_nxt[crf_pkg::ST_PARITY] = 1'b0;
    end

    // Push pre-increments, pop post-decrements
    wire [7:0] sp_push = stack_top_ptr_r + 8'h01;
    wire [7:0] sp_nxt  = i_stack.push ? sp_push
                       : i_stack.pop ? stack_top_ptr_r - 8'h01
                       : (wr_en && sel_sp) ? wval_sp : stack_top_ptr_r;

    // ------------------------------------------------------------------
    // Working register bank addressing
    // ------------------------------------------------------------------
    wire [1:0] bank = {status_r[crf_pkg::ST_BANK_HI],
                       status_r[crf_pkg::ST_BANK_LO]};
    wire [4:0] wreg_addr = {bank, i_wreg.idx};

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            stack_top_ptr_r    <= crf_pkg::STACK_RST;
            table_base_lo_r    <= crf_pkg::TBL_RST[7:0];
            table_base_hi_r    <= crf_pkg::TBL_RST[15:8];
            fetch_counter_r    <= crf_pkg::FETCH_RST;
            main_operand_reg_r <= crf_pkg::OPND_RST;
            aux_operand_reg_r  <= crf_pkg::OPND_RST;
            status_r           <= crf_pkg::STATUS_RST;
        end else begin
            stack_top_ptr_r    <= sp_nxt;
            if (wr_en && sel_lo) begin
                table_base_lo_r <= wval_lo;
            end
            if (wr_en && sel_hi) begin
                table_base_hi_r <= wval_hi;
            end
            if (i_fetch_load) begin
                fetch_counter_r <= i_fetch_addr;
            end else if (i_fetch_inc) begin
                fetch_counter_r <= fetch_counter_r + 16'h0001;
            end
            main_operand_reg_r <= a_nxt;
            aux_operand_reg_r  <= b_nxt;
            status_r           <= st_nxt;
        end
    end

    // Bank storage has no reset, like plain internal memory
    always_ff @(posedge i_clk) begin
        if (i_wreg.req && i_wreg.wr) begin
            wreg_mem[wreg_addr] <= i_wreg.wdata;
        end
        wreg_rdata_r <= wreg_mem[wreg_addr];
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            sfr_rdata_r <= 8'h00;
            sfr_bit_r   <= 1'b0;
            sfr_hit_r   <= 1'b0;
        end else begin
            sfr_rdata_r <= acc_ok ? read_byte : 8'h00;
            sfr_bit_r   <= acc_ok && read_byte[i_sfr.bit_sel];
            sfr_hit_r   <= acc_ok && sel_any;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign o_sfr_rdata        = sfr_rdata_r;
    assign o_sfr_bit          = sfr_bit_r;
    assign o_sfr_hit          = sfr_hit_r;
    assign o_wreg_rdata       = wreg_rdata_r;
    assign o_stack_addr       = sp_push;
    assign o_table_base_ptr   = {table_base_hi_r, table_base_lo_r};
    assign o_fetch_counter    = fetch_counter_r;
    assign o_main_operand_reg = main_operand_reg_r;
    assign o_aux_operand_reg  = aux_operand_reg_r;
    assign o_core_status_word = status_view;
endmodule
`default_nettype wire

//--- src/crf_pkg.sv
// Package of constants and types for the core register file
package crf_pkg;

    // ------------------------------------------------------------------
    // Special register addresses
    // ------------------------------------------------------------------
    localparam logic [7:0] SFR_BASE_ADDR    = 8'h80;
    localparam logic [7:0] STACK_ADDR       = 8'h81;
    localparam logic [7:0] TBL_LO_ADDR      = 8'h82;
    localparam logic [7:0] TBL_HI_ADDR      = 8'h83;
    localparam logic [7:0] STATUS_ADDR      = 8'hd0;
    localparam logic [7:0] MAIN_OP_ADDR     = 8'he0;
    localparam logic [7:0] AUX_OP_ADDR      = 8'hf0;
    localparam logic [7:0] UNDEF_READ_VAL   = 8'h00;

    // ------------------------------------------------------------------
    // Reset values and bank layout
    // ------------------------------------------------------------------
    localparam logic [7:0]  STACK_RST       = 8'h07;
    localparam logic [15:0] FETCH_RST       = 16'h0000;
    localparam logic [15:0] TBL_RST         = 16'h0000;
    localparam logic [7:0]  OPND_RST        = 8'h00;
    localparam logic [7:0]  STATUS_RST      = 8'h00;
    localparam logic [7:0]  BANK_STRIDE     = 8'h08;
    localparam int          WREG_DEPTH      = 32;
    localparam logic [7:0]  PRODUCT_LIMIT   = 8'hff;

    // ------------------------------------------------------------------
    // Status word bit positions
    // ------------------------------------------------------------------
    localparam int ST_CARRY     = 7;
    localparam int ST_HALF      = 6;
    localparam int ST_USER      = 5;
    localparam int ST_BANK_HI   = 4;
    localparam int ST_BANK_LO   = 3;
    localparam int ST_SIGN_ERR  = 2;
    localparam int ST_PARITY    = 0;

    // ------------------------------------------------------------------
    // Arithmetic operation codes from the execution unit
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CRF_OP_NONE             = 4'h0,
        CRF_OP_ADD              = 4'h1,
        CRF_OP_ADD_CARRY        = 4'h2,
        CRF_OP_SUBTRACT_BORROW  = 4'h3,
        CRF_OP_PRODUCT          = 4'h4,
        CRF_OP_DIVIDE           = 4'h5,
        CRF_OP_ROT_LEFT_CARRY   = 4'h6,
        CRF_OP_ROT_RIGHT_CARRY  = 4'h7,
        CRF_OP_CLEAR_SIGN_ERROR = 4'h8
    } crf_op_type;

    typedef struct packed {
        logic       req;
        logic       wr;
        logic       bit_mode;
        logic [7:0] addr;
        logic [2:0] bit_sel;
        logic [7:0] wdata;
    } crf_sfr_req_type;

    typedef struct packed {
        logic       req;
        logic       wr;
        logic [2:0] idx;
        logic [7:0] wdata;
    } crf_wreg_req_type;

    typedef struct packed {
        logic push;
        logic pop;
    } crf_stack_req_type;

endpackage

//--- src/crf_alu_flags.sv
// Arithmetic unit computing results and status flags
`timescale 1ns/1ps
`default_nettype none
module crf_alu_flags (
    input  wire crf_pkg::crf_op_type i_op,
    input  wire logic [7:0]          i_a,
    input  wire logic [7:0]          i_b,
    input  wire logic                i_cy,
    output logic [7:0]               o_res_a,
    output logic [7:0]               o_res_b,
    output logic                     o_cy,
    output logic                     o_half,
    output logic                     o_sign_err,
    output logic                     o_arith,
    output logic                     o_cy_upd
);
    // ------------------------------------------------------------------
    // Add and subtract with nibble tap
    // ------------------------------------------------------------------
    wire       use_cin  = (i_op != crf_pkg::CRF_OP_ADD);
    wire       is_sub   = (i_op == crf_pkg::CRF_OP_SUBTRACT_BORROW);
    wire       cin      = use_cin & i_cy;
    wire [7:0] opnd     = is_sub ? ~i_b : i_b;
    wire       cin_eff  = is_sub ? ~cin : cin;
    wire [4:0] lo_sum   = {1'b0, i_a[3:0]} + {1'b0, opnd[3:0]}
                          + {4'h0, cin_eff};
    wire [8:0] full_sum = {1'b0, i_a} + {1'b0, opnd} + {8'h00, cin_eff};
    wire [15:0] prod    = i_a * i_b;
    wire        div_z   = (i_b == 8'h00);
    wire [7:0]  quot    = div_z ? 8'hff : i_a / i_b;
    wire [7:0]  remn    = div_z ? 8'h00 : i_a % i_b;
    // Sign change: operands agree in sign but the result does not
    wire        add_ov  = (i_a[7] == opnd[7]) && (full_sum[7] != i_a[7]);

    always_comb begin
        o_res_a    = i_a;
        o_res_b    = i_b;
        o_cy       = i_cy;
        o_half     = 1'b0;
        o_sign_err = 1'b0;
        o_arith    = 1'b0;
        o_cy_upd   = 1'b0;
        unique case (i_op)
            crf_pkg::CRF_OP_ADD, crf_pkg::CRF_OP_ADD_CARRY,
            crf_pkg::CRF_OP_SUBTRACT_BORROW: begin
                o_res_a    = full_sum[7:0];
                // Subtract produces borrow as inverted carry
                o_cy       = is_sub ? ~full_sum[8] : full_sum[8];
                o_half     = is_sub ? ~lo_sum[4] : lo_sum[4];
                o_sign_err = add_ov;
                o_arith    = 1'b1;
                o_cy_upd   = 1'b1;
            end
            crf_pkg::CRF_OP_PRODUCT: begin
                o_res_a    = prod[7:0];
                o_res_b    = prod[15:8];
                o_cy       = 1'b0;
                o_sign_err = (prod > {8'h00, crf_pkg::PRODUCT_LIMIT});
                o_arith    = 1'b1;
                o_cy_upd   = 1'b1;
            end
            crf_pkg::CRF_OP_DIVIDE: begin
                o_res_a    = quot;
                o_res_b    = remn;
                o_cy       = 1'b0;
                o_sign_err = div_z;
                o_arith    = 1'b1;
                o_cy_upd   = 1'b1;
            end
            crf_pkg::CRF_OP_ROT_LEFT_CARRY: begin
                o_res_a  = {i_a[6:0], i_cy};
                o_cy     = i_a[7];
                o_cy_upd = 1'b1;
            end
            crf_pkg::CRF_OP_ROT_RIGHT_CARRY: begin
                o_res_a  = {i_cy, i_a[7:1]};
                o_cy     = i_a[0];
                o_cy_upd = 1'b1;
            end
            default: begin
            end
        endcase
    end
endmodule
`default_nettype wire

//--- verif/crf_core_regs_sva.sv
// Assertion checker for the core register file
`timescale 1ns/1ps
`default_nettype none
module crf_core_regs_sva (
    input wire logic                       i_clk,
    input wire logic                       i_resetn,
    input wire crf_pkg::crf_sfr_req_type   i_sfr,
    input wire crf_pkg::crf_stack_req_type i_stack,
    input wire crf_pkg::crf_op_type        i_op,
    input wire logic                       i_fetch_inc,
    input wire logic                       i_fetch_load,
    input wire logic [15:0]                i_fetch_addr,
    input wire logic [7:0]                 o_sfr_rdata,
    input wire logic                       o_sfr_hit,
    input wire logic [7:0]                 o_stack_addr,
    input wire logic [15:0]                o_fetch_counter,
    input wire logic [7:0]                 o_main_operand_reg,
    input wire logic [7:0]                 o_aux_operand_reg,
    input wire logic [7:0]                 o_core_status_word
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);

    stack_push_a: assert property (i_stack.push |=>
        o_stack_addr == $past(o_stack_addr) + 8'h01) else $error("push step");
    stack_pop_a: assert property (i_stack.pop && !i_stack.push |=>
        o_stack_addr == $past(o_stack_addr) - 8'h01) else $error("pop step");
    reset_vals_a: assert property (disable iff (1'b0) !i_resetn |=>
        o_stack_addr == 8'h08 && o_fetch_counter == 16'h0000 &&
        o_core_status_word[4:3] == 2'h0) else $error("reset values");
    parity_live_a: assert property (
        o_core_status_word[0] == ^o_main_operand_reg) else $error("parity");
    low_addr_a: assert property (i_sfr.req && !i_sfr.addr[7] |=>
        !o_sfr_hit && o_sfr_rdata == 8'h00) else $error("low address hit");
    bit_refuse_a: assert property (i_sfr.req && i_sfr.bit_mode &&
        i_sfr.addr[2:0] != 3'h0 |=> !o_sfr_hit) else $error("bit access hit");
    clear_ov_a: assert property (
        i_op == crf_pkg::CRF_OP_CLEAR_SIGN_ERROR |=> !o_core_status_word[2])
        else $error("overflow not cleared");
    product_a: assert property (i_op == crf_pkg::CRF_OP_PRODUCT |=>
        {o_aux_operand_reg, o_main_operand_reg} ==
        16'($past(o_main_operand_reg)) * 16'($past(o_aux_operand_reg)) &&
        o_core_status_word[2] == (o_aux_operand_reg != 8'h00) &&
        !o_core_status_word[7]) else $error("product result");
    add_flags_a: assert property (i_op == crf_pkg::CRF_OP_ADD |=>
        o_core_status_word[7] == (9'($past(o_main_operand_reg)) +
        9'($past(o_aux_operand_reg)) > 9'h0ff) &&
        o_core_status_word[6] == (9'($past(o_main_operand_reg) & 8'h0f) +
        9'($past(o_aux_operand_reg) & 8'h0f) > 9'h00f))
        else $error("add carry flags");
    fetch_load_a: assert property (i_fetch_load |=>
        o_fetch_counter == $past(i_fetch_addr)) else $error("fetch load");
    fetch_inc_a: assert property (i_fetch_inc && !i_fetch_load |=>
        o_fetch_counter == $past(o_fetch_counter) + 16'h0001)
        else $error("fetch step");
endmodule
bind crf_core_regs crf_core_regs_sva i_sva (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_sfr(i_sfr), .i_stack(i_stack),
    .i_op(i_op), .i_fetch_inc(i_fetch_inc), .i_fetch_load(i_fetch_load),
    .i_fetch_addr(i_fetch_addr), .o_sfr_rdata(o_sfr_rdata),
    .o_sfr_hit(o_sfr_hit), .o_stack_addr(o_stack_addr),
    .o_fetch_counter(o_fetch_counter),
    .o_main_operand_reg(o_main_operand_reg),
    .o_aux_operand_reg(o_aux_operand_reg),
    .o_core_status_word(o_core_status_word));
`default_nettype wire

//--- verif/crf_core_regs_tb.sv
// Testbench for the core register file
`timescale 1ns/1ps
`default_nettype none
module crf_core_regs_tb;
    logic                       i_clk;
    logic                       i_resetn;
    crf_pkg::crf_sfr_req_type   i_sfr;
    crf_pkg::crf_wreg_req_type  i_wreg;
    crf_pkg::crf_stack_req_type i_stack;
    crf_pkg::crf_op_type        i_op;
    logic                       i_fetch_inc;
    logic                       i_fetch_load;
    logic [15:0]                i_fetch_addr;
    logic [7:0]                 o_sfr_rdata;
    logic                       o_sfr_bit;
    logic                       o_sfr_hit;
    logic [7:0]                 o_wreg_rdata;
    logic [7:0]                 o_stack_addr;
    logic [15:0]                o_table_base_ptr;
    logic [15:0]                o_fetch_counter;
    logic [7:0]                 o_main_operand_reg;
    logic [7:0]                 o_aux_operand_reg;
    logic [7:0]                 o_core_status_word;
    int                         n_errors;
    int                         compares;
    // Op, main, aux, status in, then expected main, aux, status
    logic [7:0]                 tv [12][7] = '{
        '{8'h01, 8'h7f, 8'h01, 8'h00, 8'h80, 8'h01, 8'h45},
        '{8'h08, 8'h80, 8'h01, 8'h04, 8'h80, 8'h01, 8'h01},
        '{8'h03, 8'h80, 8'h01, 8'h00, 8'h7f, 8'h01, 8'h45},
        '{8'h04, 8'h10, 8'h20, 8'h00, 8'h00, 8'h02, 8'h04},
        '{8'h04, 8'h0f, 8'h11, 8'h04, 8'hff, 8'h00, 8'h00},
        '{8'h05, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00, 8'h04},
        '{8'h05, 8'h07, 8'h02, 8'h04, 8'h03, 8'h01, 8'h00},
        '{8'h02, 8'hff, 8'h01, 8'h80, 8'h01, 8'h01, 8'hc1},
        '{8'h06, 8'h01, 8'h55, 8'h80, 8'h03, 8'h55, 8'h00},
        '{8'h07, 8'h03, 8'h55, 8'h00, 8'h01, 8'h55, 8'h81},
        '{8'h01, 8'h01, 8'h01, 8'h80, 8'h02, 8'h01, 8'h01},
        '{8'h03, 8'h00, 8'h01, 8'h80, 8'hfe, 8'h01, 8'hc1}};

    crf_core_regs i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_sfr(i_sfr),
        .i_wreg(i_wreg), .i_stack(i_stack), .i_op(i_op),
        .i_fetch_inc(i_fetch_inc), .i_fetch_load(i_fetch_load),
        .i_fetch_addr(i_fetch_addr), .o_sfr_rdata(o_sfr_rdata),
        .o_sfr_bit(o_sfr_bit), .o_sfr_hit(o_sfr_hit),
        .o_wreg_rdata(o_wreg_rdata), .o_stack_addr(o_stack_addr),
        .o_table_base_ptr(o_table_base_ptr),
        .o_fetch_counter(o_fetch_counter),
        .o_main_operand_reg(o_main_operand_reg),
        .o_aux_operand_reg(o_aux_operand_reg),
        .o_core_status_word(o_core_status_word));

    // --------
    // Tasks
    // --------
    task automatic report_and_stop();
        $display("compares %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One special access; outputs are sampled just after the taking edge
    task automatic acc(input logic wr, bm, input logic [7:0] ad,
                       input logic [2:0] bs, input logic [7:0] wd);
        @(posedge i_clk);
        i_sfr <= '{1'b1, wr, bm, ad, bs, wd};
        @(posedge i_clk);
        i_sfr <= '0;
        #1;
    endtask
    task automatic run_op(input logic [7:0] op);
        @(posedge i_clk);
        i_op <= crf_pkg::crf_op_type'(op[3:0]);
        @(posedge i_clk);
        i_op <= crf_pkg::CRF_OP_NONE;
        #1;
    endtask
    task automatic stk(input logic ps, pp, input logic [7:0] e);
        @(posedge i_clk);
        i_stack <= '{ps, pp};
        @(posedge i_clk);
        i_stack <= '0;
        #1;
        chk("stack_addr", {8'h00, e}, {8'h00, o_stack_addr});
    endtask
    task automatic fch(input logic inc, ld, input logic [15:0] a, e);
        @(posedge i_clk);
        i_fetch_inc <= inc;
        i_fetch_load <= ld;
        i_fetch_addr <= a;
        @(posedge i_clk);
        i_fetch_inc <= 1'b0;
        i_fetch_load <= 1'b0;
        #1;
        chk("fetch_counter", e, o_fetch_counter);
    endtask
    // Working register access; the read data trails the index by one edge
    task automatic wrg(input logic wr, input logic [2:0] ix,
                       input logic [7:0] d);
        @(posedge i_clk);
        i_wreg <= '{1'b1, wr, ix, d};
        @(posedge i_clk);
        i_wreg <= '{1'b0, 1'b0, ix, 8'h00};
        #1;
    endtask

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    initial begin
        repeat (6000) @(posedge i_clk);
        n_errors++;
        $display("timeout waiting for the main sequence");
        report_and_stop();
    end

    // --------
    // Main sequence
    // --------
    initial begin
        i_resetn = 1'b0;
        i_sfr = '0;
        i_wreg = '0;
        i_stack = '0;
        i_op = crf_pkg::CRF_OP_NONE;
        i_fetch_inc = 1'b0;
        i_fetch_load = 1'b0;
        i_fetch_addr = 16'h0000;
        n_errors = 0;
        compares = 0;
        repeat (4) @(posedge i_clk);
        i_resetn <= 1'b1;
        #1;
        chk("fetch_counter", 16'h0000, o_fetch_counter);
        chk("status", 16'h0000, {8'h00, o_core_status_word});
        acc(1'b0, 1'b0, crf_pkg::STACK_ADDR, 3'h0, 8'h00);
        chk("stack_read", 16'h0107, {7'h00, o_sfr_hit, o_sfr_rdata});
        $display("test reset done");
        stk(1'b1, 1'b0, 8'h09);
        stk(1'b1, 1'b0, 8'h0a);
        stk(1'b0, 1'b1, 8'h09);
        stk(1'b1, 1'b1, 8'h0a);
        $display("test stack done");
        acc(1'b1, 1'b0, crf_pkg::TBL_LO_ADDR, 3'h0, 8'h34);
        acc(1'b1, 1'b0, crf_pkg::TBL_HI_ADDR, 3'h0, 8'h12);
        chk("table_base", 16'h1234, o_table_base_ptr);
        fch(1'b1, 1'b0, 16'h0000, 16'h0001);
        fch(1'b1, 1'b1, 16'habcd, 16'habcd);
        fch(1'b0, 1'b1, 16'hffff, 16'hffff);
        fch(1'b1, 1'b0, 16'h0000, 16'h0000);
        $display("test pointers done");
        for (int b = 0; b < 8; b++) begin
            acc(1'b1, 1'b0, crf_pkg::STATUS_ADDR, 3'h0, 8'(b % 4) << 3);
            wrg(b < 4, 3'h5, 8'ha0 + 8'(b % 4));
            if (b >= 4) begin
                chk("wreg", 16'h00a0 + 16'(b % 4), {8'h00, o_wreg_rdata});
            end
        end
        $display("test banks done");
        for (int i = 0; i < 12; i++) begin
            acc(1'b1, 1'b0, crf_pkg::MAIN_OP_ADDR, 3'h0, tv[i][1]);
            acc(1'b1, 1'b0, crf_pkg::AUX_OP_ADDR, 3'h0, tv[i][2]);
            acc(1'b1, 1'b0, crf_pkg::STATUS_ADDR, 3'h0, tv[i][3]);
            run_op(tv[i][0]);
            chk("operands", {tv[i][5], tv[i][4]},
                {o_aux_operand_reg, o_main_operand_reg});
            chk("status", {8'h00, tv[i][6]}, {8'h00, o_core_status_word});
        end
        $display("test arithmetic done");
        acc(1'b1, 1'b0, crf_pkg::MAIN_OP_ADDR, 3'h0, 8'h7f);
        acc(1'b1, 1'b0, crf_pkg::STATUS_ADDR, 3'h0, 8'h00);
        acc(1'b1, 1'b1, crf_pkg::STATUS_ADDR, 3'h5, 8'h01);
        run_op(8'h01);
        chk("status", 16'h0065, {8'h00, o_core_status_word});
        acc(1'b0, 1'b1, crf_pkg::MAIN_OP_ADDR, 3'h7, 8'h00);
        chk("bit_read", 16'h0003, {14'h0000, o_sfr_hit, o_sfr_bit});
        acc(1'b0, 1'b0, 8'h7f, 3'h0, 8'h00);
        chk("low_read", 16'h0000, {7'h00, o_sfr_hit, o_sfr_rdata});
        acc(1'b1, 1'b1, crf_pkg::STACK_ADDR, 3'h1, 8'h01);
        chk("stack_addr", 16'h000a, {7'h00, o_sfr_hit, o_stack_addr});
        acc(1'b1, 1'b0, 8'h84, 3'h0, 8'hff);
        acc(1'b0, 1'b0, 8'h84, 3'h0, 8'h00);
        chk("unmapped", 16'h0000, {7'h00, o_sfr_hit, o_sfr_rdata});
        $display("test special space done");
        // A second reset in mid-run must restore the stack base
        @(posedge i_clk);
        i_resetn <= 1'b0;
        @(posedge i_clk);
        i_resetn <= 1'b1;
        #1;
        chk("stack_addr", 16'h0008, {8'h00, o_stack_addr});
        $display("test second reset done");
        report_and_stop();
    end
endmodule
`default_nettype wire
